// [rtl/bmt_bmc_enc.sv]
// biphase-mark line encoder, one sub-frame at a time
`timescale 1ns/1ps
module bmt_bmc_enc (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        clr_i,
  input  wire logic        active_i,
  input  wire logic        tick_i,
  input  wire logic [27:0] sf_data_i,
  input  wire logic [7:0]  pre_i,
  output logic             take_o,
  output logic             line_o
);
  logic [5:0]  st_r;
  logic [5:0]  nst;
  logic [27:0] data_r;
  logic [7:0]  pre_r;
  logic        ref_r;
  logic        line_r;
  logic        bit_cur;

  assign take_o  = active_i && tick_i && (st_r == bmt_pkg::LAST_STATE);
  assign line_o  = line_r;
  assign nst     = st_r + 6'h01;
  assign bit_cur = data_r[st_r[5:1] - bmt_pkg::DATA_OFS];

  // ==========================================================
  // state position within the sub-frame
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || clr_i || !active_i) begin
      st_r <= bmt_pkg::LAST_STATE;
    end else if (tick_i) begin
      st_r <= nst;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || clr_i) begin
      data_r <= '0;
      pre_r  <= '0;
      ref_r  <= 1'b0;
    end else if (take_o) begin
      data_r <= sf_data_i;
      pre_r  <= pre_i;
      ref_r  <= line_r;
    end
  end

  // ==========================================================
  // line level
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || clr_i) begin
      line_r <= 1'b0;
    end else if (take_o) begin
      line_r <= pre_i[7] ^ line_r;
    end else if (active_i && tick_i) begin
      if (nst < bmt_pkg::PRE_LEN) begin
        line_r <= pre_r[3'h7 - nst[2:0]] ^ ref_r;
      end else if (!nst[0]) begin
        line_r <= ~line_r;
      end else if (bit_cur) begin
        line_r <= ~line_r;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i || clr_i);

  AST_BMC_FIRST: assert property (tick_i && active_i && !take_o && st_r >= 6'h07 && st_r[0]
      |=> line_r != $past(line_r)) else $error("bit cell did not start with a transition");
  AST_BMC_SECOND: assert property (tick_i && active_i && st_r >= 6'h08 && !st_r[0]
      |=> (line_r ^ $past(line_r)) == $past(bit_cur)) else $error("mid-cell transition wrong");
  AST_PRE_START: assert property (take_o ##1 active_i [*1]
      |-> line_r != $past(line_r)) else $error("preamble did not invert");
  AST_CLR_LINE: assert property (disable iff (srst_i) clr_i
      |=> !line_r && st_r == bmt_pkg::LAST_STATE) else $error("line not cleared");
endmodule

// [rtl/bmt_pkg.sv]
// constants shared by the biphase audio transmitter files
package bmt_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0]  OFS_CFG     = 8'h00;
  localparam logic [7:0]  OFS_BUFLVL  = 8'h04;
  localparam logic [7:0]  OFS_DMA     = 8'h08;
  localparam logic [7:0]  OFS_INTCR   = 8'h0C;
  localparam logic [7:0]  OFS_INTSR   = 8'h10;
  localparam logic [7:0]  OFS_XFER    = 8'h18;
  localparam logic [7:0]  OFS_SMP     = 8'h20;
  localparam logic [7:0]  OFS_VLD     = 8'h60;
  localparam logic [7:0]  OFS_USR     = 8'h90;
  localparam logic [7:0]  OFS_CHS     = 8'hC0;
  localparam logic [7:0]  TBL_SPAN    = 8'h30;
  localparam int          TBL_WORDS   = 12;
  // ==========================================================
  // register fields
  localparam logic [31:0] CFG_WMASK   = 32'h00FF007F;
  localparam logic [31:0] DMA_WMASK   = 32'h0000003F;
  localparam logic [31:0] INTCR_WMASK = 32'h000003F8;
  localparam logic [31:0] XFER_WMASK  = 32'h00000001;
  localparam int          CFG_RAT_LSB = 16;
  localparam int          CFG_CLR_BIT = 7;
  localparam int          CFG_CHS_BIT = 6;
  localparam int          CFG_USR_BIT = 5;
  localparam int          CFG_VLD_BIT = 4;
  localparam int          CFG_LJ_BIT  = 3;
  localparam int          CFG_PK_BIT  = 2;
  localparam int          CFG_WID_LSB = 0;
  localparam logic [1:0]  WID_20      = 2'h1;
  localparam logic [1:0]  WID_24      = 2'h2;
  localparam int          DMA_EN_BIT  = 5;
  localparam int          DMA_WM_LSB  = 0;
  localparam int          INT_CLR_BIT = 16;
  localparam int          INT_THR_LSB = 5;
  localparam int          INT_EMP_BIT = 4;
  localparam int          INT_BLK_BIT = 3;
  localparam int          XFER_GO_BIT = 0;
  // ==========================================================
  // sample handling
  localparam logic [5:0]  FIFO_FULL   = 6'h20;
  localparam logic [4:0]  RJ_SH_16    = 5'h10;
  localparam logic [4:0]  RJ_SH_20    = 5'h0C;
  localparam logic [4:0]  RJ_SH_24    = 5'h08;
  localparam logic [23:0] MASK_16     = 24'hFFFF00;
  localparam logic [23:0] MASK_20     = 24'hFFFFF0;
  localparam logic [23:0] MASK_24     = 24'hFFFFFF;
  // ==========================================================
  // framing and line code
  localparam logic [7:0]  LAST_FRAME  = 8'hBF;
  localparam logic [5:0]  LAST_STATE  = 6'h3F;
  localparam logic [5:0]  PRE_LEN     = 6'h08;
  localparam logic [4:0]  DATA_OFS    = 5'h04;
  localparam logic [7:0]  PRE_B       = 8'hE8;
  localparam logic [7:0]  PRE_M       = 8'hE2;
  localparam logic [7:0]  PRE_W       = 8'hE4;
  localparam logic [1:0]  HRESP_OKAY  = 2'h0;
endpackage

// [rtl/bmt_top.sv]
// register file, sample buffer and sub-frame builder of the biphase audio transmitter
`timescale 1ns/1ps
module bmt_top (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        hsel_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic      [1:0]  hresp_o,
  output logic             dma_tx_req_o,
  output logic             irq_o,
  output logic             bmc_tx_o
);
  // ==========================================================
  // helpers
  function automatic logic bmt_tbl_hit(input logic [7:0] a, input logic [7:0] b);
    return (a >= b) && (a < b + bmt_pkg::TBL_SPAN) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] bmt_tbl_idx(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] d;
    d = a - b;
    return d[5:2];
  endfunction

  // places the sample left aligned in the 24-bit audio field
  function automatic logic [23:0] bmt_align(input logic [31:0] w, input logic [1:0] wid,
                                            input logic lj, input logic pk, input logic hi);
    logic [31:0] s;
    logic [23:0] m;
    s = lj ? w : (w << bmt_pkg::RJ_SH_16);
    m = bmt_pkg::MASK_16;
    if (pk) begin
      s = {(hi ? w[31:16] : w[15:0]), 16'h0000};
    end else begin
      case (wid)
        bmt_pkg::WID_20: begin
          s = lj ? w : (w << bmt_pkg::RJ_SH_20);
          m = bmt_pkg::MASK_20;
        end
        bmt_pkg::WID_24: begin
          s = lj ? w : (w << bmt_pkg::RJ_SH_24);
          m = bmt_pkg::MASK_24;
        end
        default: begin
        end
      endcase
    end
    return s[31:8] & m;
  endfunction

  // ==========================================================
  // declarations
  logic [31:0] cfg_r;
  logic [31:0] dma_r;
  logic [31:0] intcr_r;
  logic [31:0] xfer_r;
  logic [31:0] vld_r [0:bmt_pkg::TBL_WORDS-1];
  logic [31:0] usr_r [0:bmt_pkg::TBL_WORDS-1];
  logic [31:0] chs_r [0:bmt_pkg::TBL_WORDS-1];
  logic [31:0] mem_r [0:31];
  logic [4:0]  wp_r;
  logic [4:0]  rp_r;
  logic [5:0]  lvl_r;
  logic        wr_r;
  logic [7:0]  waddr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_nxt;
  logic        blk_st_r;
  logic        emp_st_r;
  logic [7:0]  div_r;
  logic [7:0]  frame_r;
  logic        sub_r;
  logic        half_r;
  logic        last_r;
  logic        a_acc;
  logic        clr;
  logic        push;
  logic        pop;
  logic        have;
  logic        run;
  logic        tick;
  logic        take;
  logic        blk_evt;
  logic        wr_cfg;
  logic        wr_dma;
  logic        wr_intcr;
  logic [7:0]  ratio;
  logic [5:0]  wm;
  logic [5:0]  thr;
  logic        pk;
  logic [8:0]  sfi;
  logic        v_bit;
  logic        u_bit;
  logic        c_bit;
  logic [23:0] audio;
  logic [27:0] sf_word;
  logic [7:0]  pre;

  // ==========================================================
  // bus slave
  assign a_acc       = hsel_i && hready_i && htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o     = bmt_pkg::HRESP_OKAY;
  assign hrdata_o    = hrdata_r;
  assign wr_cfg      = wr_r && (waddr_r == bmt_pkg::OFS_CFG);
  assign wr_dma      = wr_r && (waddr_r == bmt_pkg::OFS_DMA);
  assign wr_intcr    = wr_r && (waddr_r == bmt_pkg::OFS_INTCR);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wr_r    <= 1'b0;
      waddr_r <= '0;
    end else begin
      wr_r <= a_acc && hwrite_i;
      if (a_acc) begin
        waddr_r <= haddr_i[7:0];
      end
    end
  end

  always_comb begin
    rd_nxt = '0;
    case (haddr_i[7:0])
      bmt_pkg::OFS_CFG:    rd_nxt = cfg_r;
      bmt_pkg::OFS_BUFLVL: rd_nxt = 32'(lvl_r);
      bmt_pkg::OFS_DMA:    rd_nxt = dma_r;
      bmt_pkg::OFS_INTCR:  rd_nxt = intcr_r;
      bmt_pkg::OFS_INTSR: begin
        rd_nxt[bmt_pkg::INT_EMP_BIT] = emp_st_r;
        rd_nxt[bmt_pkg::INT_BLK_BIT] = blk_st_r;
      end
      bmt_pkg::OFS_XFER:   rd_nxt = xfer_r;
      default: begin
        if (bmt_tbl_hit(haddr_i[7:0], bmt_pkg::OFS_VLD)) begin
          rd_nxt = vld_r[bmt_tbl_idx(haddr_i[7:0], bmt_pkg::OFS_VLD)];
        end else if (bmt_tbl_hit(haddr_i[7:0], bmt_pkg::OFS_USR)) begin
          rd_nxt = usr_r[bmt_tbl_idx(haddr_i[7:0], bmt_pkg::OFS_USR)];
        end else if (bmt_tbl_hit(haddr_i[7:0], bmt_pkg::OFS_CHS)) begin
          rd_nxt = chs_r[bmt_tbl_idx(haddr_i[7:0], bmt_pkg::OFS_CHS)];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      hrdata_r <= '0;
    end else if (a_acc && !hwrite_i) begin
      hrdata_r <= rd_nxt;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cfg_r   <= '0;
      dma_r   <= '0;
      intcr_r <= '0;
      xfer_r  <= '0;
    end else begin
      if (wr_cfg) begin
        cfg_r <= hwdata_i & bmt_pkg::CFG_WMASK;
      end
      if (wr_dma) begin
        dma_r <= hwdata_i & bmt_pkg::DMA_WMASK;
      end
      if (wr_intcr) begin
        intcr_r <= hwdata_i & bmt_pkg::INTCR_WMASK;
      end
      if (wr_r && (waddr_r == bmt_pkg::OFS_XFER)) begin
        xfer_r <= hwdata_i & bmt_pkg::XFER_WMASK;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int i = 0; i < bmt_pkg::TBL_WORDS; i++) begin
        vld_r[i] <= '0;
        usr_r[i] <= '0;
        chs_r[i] <= '0;
      end
    end else if (wr_r) begin
      if (bmt_tbl_hit(waddr_r, bmt_pkg::OFS_VLD)) begin
        vld_r[bmt_tbl_idx(waddr_r, bmt_pkg::OFS_VLD)] <= hwdata_i;
      end
      if (bmt_tbl_hit(waddr_r, bmt_pkg::OFS_USR)) begin
        usr_r[bmt_tbl_idx(waddr_r, bmt_pkg::OFS_USR)] <= hwdata_i;
      end
      if (bmt_tbl_hit(waddr_r, bmt_pkg::OFS_CHS)) begin
        chs_r[bmt_tbl_idx(waddr_r, bmt_pkg::OFS_CHS)] <= hwdata_i;
      end
    end
  end

  assign clr   = wr_cfg && hwdata_i[bmt_pkg::CFG_CLR_BIT];
  assign run   = xfer_r[bmt_pkg::XFER_GO_BIT];
  assign ratio = cfg_r[bmt_pkg::CFG_RAT_LSB +: 8];
  assign wm    = {1'b0, dma_r[bmt_pkg::DMA_WM_LSB +: 5]};
  assign thr   = {1'b0, intcr_r[bmt_pkg::INT_THR_LSB +: 5]};
  assign pk    = cfg_r[bmt_pkg::CFG_PK_BIT];

  // ==========================================================
  // sample buffer
  assign push = wr_r && (waddr_r == bmt_pkg::OFS_SMP) && (lvl_r != bmt_pkg::FIFO_FULL);
  assign have = lvl_r != 6'h00;
  assign pop  = take && have && (!pk || half_r);

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wp_r] <= hwdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      lvl_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 5'h01;
      end
      if (pop) begin
        rp_r <= rp_r + 5'h01;
      end
      case ({push, pop})
        2'b10:   lvl_r <= lvl_r + 6'h01;
        2'b01:   lvl_r <= lvl_r - 6'h01;
        default: lvl_r <= lvl_r;
      endcase
    end
  end

  // ==========================================================
  // bit-rate divider: one line state per ratio clocks, one per clock when ratio is 0
  assign tick = (ratio == 8'h00) || (div_r == ratio - 8'h01);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || clr || !run || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ==========================================================
  // sub-frame builder
  assign sfi   = {frame_r, sub_r};
  assign v_bit = cfg_r[bmt_pkg::CFG_VLD_BIT] && vld_r[sfi[8:5]][sfi[4:0]];
  assign u_bit = cfg_r[bmt_pkg::CFG_USR_BIT] && usr_r[sfi[8:5]][sfi[4:0]];
  assign c_bit = cfg_r[bmt_pkg::CFG_CHS_BIT] && chs_r[sfi[8:5]][sfi[4:0]];
  assign audio = have ? bmt_align(mem_r[rp_r], cfg_r[bmt_pkg::CFG_WID_LSB +: 2],
                                  cfg_r[bmt_pkg::CFG_LJ_BIT], pk, half_r) : 24'h000000;
  assign sf_word = {^{c_bit, u_bit, v_bit, audio}, c_bit, u_bit, v_bit, audio};
  assign pre = sub_r ? bmt_pkg::PRE_W :
               ((frame_r == 8'h00) ? bmt_pkg::PRE_B : bmt_pkg::PRE_M);
  assign blk_evt = take && last_r;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || clr || !run) begin
      frame_r <= '0;
      sub_r   <= 1'b0;
      half_r  <= 1'b0;
      last_r  <= 1'b0;
    end else if (take) begin
      sub_r  <= ~sub_r;
      last_r <= sub_r && (frame_r == bmt_pkg::LAST_FRAME);
      if (sub_r) begin
        frame_r <= (frame_r == bmt_pkg::LAST_FRAME) ? 8'h00 : frame_r + 8'h01;
      end
      half_r <= pk && (have ? ~half_r : half_r);
    end
  end

  bmt_bmc_enc u_enc (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .clr_i     (clr),
    .active_i  (run),
    .tick_i    (tick),
    .sf_data_i (sf_word),
    .pre_i     (pre),
    .take_o    (take),
    .line_o    (bmc_tx_o)
  );

  // ==========================================================
  // status, interrupt and dma request
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      blk_st_r <= 1'b0;
      emp_st_r <= 1'b0;
    end else begin
      emp_st_r <= lvl_r <= thr;
      if (blk_evt) begin
        blk_st_r <= 1'b1;
      end else if (wr_intcr && hwdata_i[bmt_pkg::INT_CLR_BIT]) begin
        blk_st_r <= 1'b0;
      end
    end
  end

  assign irq_o = (emp_st_r && intcr_r[bmt_pkg::INT_EMP_BIT]) ||
                 (blk_st_r && intcr_r[bmt_pkg::INT_BLK_BIT]);
  assign dma_tx_req_o = dma_r[bmt_pkg::DMA_EN_BIT] && (lvl_r <= wm);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  AST_CLR_READS_ZERO: assert property (a_acc && !hwrite_i && haddr_i[7:0] == bmt_pkg::OFS_CFG
      |=> !hrdata_o[7]) else $error("clear bit read back as one");
  AST_DMA_GATED: assert property (wr_dma && !hwdata_i[bmt_pkg::DMA_EN_BIT]
      |=> !dma_tx_req_o) else $error("dma request while disabled");
  AST_DMA_WATERMARK: assert property (push && !pop && lvl_r == wm && !wr_dma
      |=> !dma_tx_req_o) else $error("dma request above watermark");
  AST_BLK_CLEAR: assert property (wr_intcr && hwdata_i[bmt_pkg::INT_CLR_BIT] && !blk_evt
      |=> !blk_st_r) else $error("terminate status not cleared");
  AST_BLK_SET: assert property (blk_evt && !wr_intcr && intcr_r[bmt_pkg::INT_BLK_BIT]
      |=> blk_st_r && irq_o) else $error("terminate event lost");
  AST_EMPTY_IRQ: assert property ((lvl_r <= thr && intcr_r[bmt_pkg::INT_EMP_BIT]) [*2]
      |-> irq_o) else $error("empty interrupt missing");
  AST_PUSH_LEVEL: assert property (push && !pop
      |=> lvl_r == $past(lvl_r) + 6'h01) else $error("push did not raise level");
  AST_PARITY_EVEN: assert property (take
      |-> !(^sf_word)) else $error("odd parity in sub-frame");
  AST_BLOCK_PRE_B: assert property (take && last_r
      |-> pre == bmt_pkg::PRE_B) else $error("block start without preamble B");
  AST_CHS_OFF: assert property (take && !cfg_r[bmt_pkg::CFG_CHS_BIT]
      |-> !sf_word[26]) else $error("channel status sent while disabled");
endmodule

// [tb/biphase_audio_transmitter_test.sv]
// self-checking bench for the biphase audio transmitter
`timescale 1ns/1ps
module biphase_audio_transmitter_test;
  localparam logic [7:0]  RAT = 8'h02;
  localparam logic [31:0] WRD = 32'hC3A596E7;
  localparam logic [7:0]  MD [10] = '{8'h00, 8'h08, 8'h01, 8'h09, 8'h02,
                                     8'h0A, 8'h03, 8'h0C, 8'h72, 8'h51};
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        hsel_i = 1'b0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic        mrst = 1'b0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic [1:0]  hresp_o;
  logic        dma_tx_req_o;
  logic        irq_o;
  logic        bmc_tx_o;
  logic        stb;
  logic [1:0]  pre;
  logic [27:0] bits;
  int          err;
  int          mismatches = 0;
  int          n_compared = 0;
  bmt_top dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .hsel_i(hsel_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .haddr_i(haddr_i), .hwdata_i(hwdata_i),
    .hready_i(1'b1), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .dma_tx_req_o(dma_tx_req_o), .irq_o(irq_o), .bmc_tx_o(bmc_tx_o));
  bmt_rx_model #(.R(2)) rx_u (.clk_i(clk_sys_i), .rst_i(srst_i | mrst), .line_i(bmc_tx_o),
    .stb_o(stb), .pre_o(pre), .bits_o(bits), .err_o(err));
  always #4 clk_sys_i = ~clk_sys_i;
  // =========================================================
  // bus cycles and helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    {hsel_i, htrans_i, hwrite_i, haddr_i} <= {4'hD, 24'h0, a};
    @(posedge clk_sys_i);
    {hsel_i, htrans_i, hwdata_i} <= {3'h0, d};
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    {hsel_i, htrans_i, hwrite_i, haddr_i} <= {4'hC, 24'h0, a};
    @(posedge clk_sys_i);
    {hsel_i, htrans_i} <= 3'h0;
    #1 d = hrdata_o;
  endtask
  task automatic rx(output logic [1:0] p, output logic [27:0] b);
    int t;
    t = 0;
    do begin
      @(posedge clk_sys_i);
      #1 t++;
    end while (stb !== 1'b1 && t < 1000);
    if (t >= 1000) chk(32'h0, 32'h1);
    p = pre;
    b = bits;
  endtask
  task automatic go;
    @(posedge clk_sys_i);
    mrst <= 1'b1;
    @(posedge clk_sys_i);
    mrst <= 1'b0;
    wr(bmt_pkg::OFS_XFER, 32'h1);
  endtask
  function automatic logic [23:0] aud(input logic [7:0] m, input int k);
    if (m[2]) return k ? {WRD[31:16], 8'h0} : {WRD[15:0], 8'h0};
    if (k != 0) return 24'h0;
    case (m[1:0])
      2'h1: return m[3] ? {WRD[31:12], 4'h0} : {WRD[19:0], 4'h0};
      2'h2: return m[3] ? WRD[31:8] : WRD[23:0];
      default: return m[3] ? {WRD[31:16], 8'h0} : {WRD[15:0], 8'h0};
    endcase
  endfunction
  // =========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [7:0]  ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h60, 8'h90, 8'hC0};
    foreach (ofs[i]) begin
      rd(ofs[i], d);
      chk(d, 32'h0);
    end
    wr(bmt_pkg::OFS_INTSR, 32'hFFFFFFFF);
    wr(bmt_pkg::OFS_BUFLVL, 32'hFFFFFFFF);
    wr(8'h14, 32'hFFFFFFFF);
    rd(bmt_pkg::OFS_INTSR, d);
    chk(d, 32'h10);
    rd(bmt_pkg::OFS_BUFLVL, d);
    chk(d, 32'h0);
    rd(8'h14, d);
    chk(d, 32'h0);
    rd(bmt_pkg::OFS_SMP, d);
    chk(d, 32'h0);
    chk({29'h0, hreadyout_o, hresp_o}, 32'h4);
    wr(bmt_pkg::OFS_CFG, 32'hFFFFFFFF);
    rd(bmt_pkg::OFS_CFG, d);
    chk(d, 32'h00FF007F);
    wr(bmt_pkg::OFS_DMA, 32'hFFFFFFFF);
    rd(bmt_pkg::OFS_DMA, d);
    chk(d, 32'h0000003F);
    wr(bmt_pkg::OFS_INTCR, 32'hFFFFFFFF);
    rd(bmt_pkg::OFS_INTCR, d);
    chk(d, 32'h000003F8);
    wr(bmt_pkg::OFS_XFER, 32'hFFFFFFFF);
    rd(bmt_pkg::OFS_XFER, d);
    chk(d, 32'h1);
    for (int i = 5; i < 8; i++) begin
      wr(ofs[i] + 8'h2C, 32'h80000001);
      rd(ofs[i] + 8'h2C, d);
      chk(d, 32'h80000001);
      wr(ofs[i] + 8'h2C, 32'h0);
    end
    wr(bmt_pkg::OFS_XFER, 32'h0);
    wr(bmt_pkg::OFS_CFG, {8'h0, RAT, 16'h0});
    wr(bmt_pkg::OFS_INTCR, 32'h0);
  endtask
  task automatic t_dma;
    logic [31:0] d;
    logic [1:0]  p;
    logic [27:0] b;
    int          t;
    wr(bmt_pkg::OFS_DMA, 32'h02);
    chk({31'h0, dma_tx_req_o}, 32'h0);
    wr(bmt_pkg::OFS_DMA, 32'h22);
    chk({31'h0, dma_tx_req_o}, 32'h1);
    wr(bmt_pkg::OFS_INTCR, 32'h50);
    chk({31'h0, irq_o}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(bmt_pkg::OFS_SMP, WRD);
      chk({31'h0, dma_tx_req_o}, {31'h0, i < 2});
    end
    rd(bmt_pkg::OFS_BUFLVL, d);
    chk(d, 32'h3);
    rd(bmt_pkg::OFS_INTSR, d);
    chk(d, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    go();
    t = 0;
    while (irq_o !== 1'b1 && t < 2000) begin
      @(posedge clk_sys_i);
      #1 t++;
    end
    chk({31'h0, irq_o}, 32'h1);
    rd(bmt_pkg::OFS_BUFLVL, d);
    chk(d, 32'h2);
    rd(bmt_pkg::OFS_INTSR, d);
    chk(d, 32'h10);
    repeat (3) rx(p, b);
    rd(bmt_pkg::OFS_BUFLVL, d);
    chk(d, 32'h0);
    wr(bmt_pkg::OFS_XFER, 32'h0);
    wr(bmt_pkg::OFS_DMA, 32'h0);
    wr(bmt_pkg::OFS_INTCR, 32'h0);
  endtask
  task automatic t_line;
    logic [1:0]  p;
    logic [27:0] b;
    logic [26:0] x;
    wr(bmt_pkg::OFS_VLD, 32'h1);
    wr(bmt_pkg::OFS_USR, 32'h2);
    wr(bmt_pkg::OFS_CHS, 32'h3);
    foreach (MD[i]) begin
      wr(bmt_pkg::OFS_CFG, {8'h0, RAT, 8'h0, MD[i]});
      wr(bmt_pkg::OFS_SMP, WRD);
      go();
      for (int k = 0; k < 2; k++) begin
        rx(p, b);
        x = {MD[i][6], MD[i][5] & (k == 1), MD[i][4] & (k == 0), aud(MD[i], k)};
        chk({30'h0, p}, k ? 32'h2 : 32'h0);
        chk({4'h0, b}, {4'h0, ^x, x});
      end
      chk(err, 0);
      wr(bmt_pkg::OFS_XFER, 32'h0);
    end
  endtask
  task automatic t_block;
    logic [1:0]  p;
    logic [27:0] b;
    logic [31:0] d;
    wr(bmt_pkg::OFS_CFG, {8'h0, RAT, 16'h0});
    wr(bmt_pkg::OFS_INTCR, 32'h8);
    go();
    for (int k = 0; k < 385; k++) begin
      rx(p, b);
      chk({30'h0, p}, (k % 384 == 0) ? 32'h0 : (k % 2) ? 32'h2 : 32'h1);
      if (k == 382) chk({31'h0, irq_o}, 32'h0);
    end
    chk(err, 0);
    chk({31'h0, irq_o}, 32'h1);
    rd(bmt_pkg::OFS_INTSR, d);
    chk(d & 32'h8, 32'h8);
    wr(bmt_pkg::OFS_INTCR, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(bmt_pkg::OFS_INTCR, 32'h00010000);
    rd(bmt_pkg::OFS_INTSR, d);
    chk(d & 32'h8, 32'h0);
    wr(bmt_pkg::OFS_CFG, {8'h0, RAT, 16'h0080});
    chk({31'h0, bmc_tx_o}, 32'h0);
    wr(bmt_pkg::OFS_XFER, 32'h0);
  endtask
  // =========================================================
  // sequence and watchdog
  initial begin
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_regs();
    $display("t_regs finished");
    t_dma();
    $display("t_dma finished");
    t_line();
    $display("t_line finished");
    t_block();
    $display("t_block finished");
    test_done();
  end
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    mismatches++;
    test_done();
  end
endmodule

// [tb/bmt_rx_model.sv]
// receiving-end model: recovers line states and decodes each sub-frame
`timescale 1ns/1ps
module bmt_rx_model #(
  parameter int R = 2
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        line_i,
  output logic             stb_o,
  output logic      [1:0]  pre_o,
  output logic      [27:0] bits_o,
  output int               err_o
);
  logic        prev = 1'b0;
  logic        sync = 1'b0;
  int          ph = 0;
  int          n = 0;
  logic [63:0] sh = '0;
  logic [27:0] acc = '0;
  // =========================================================
  // sample each state on its last clock, edges realign phase
  always @(posedge clk_i) begin
    logic [63:0] s;
    logic [7:0]  pn;
    logic [1:0]  pc;
    s = {sh[62:0], line_i};
    pn = s[7:0] ^ {8{~s[7]}};
    pc = (pn == bmt_pkg::PRE_B) ? 2'h0 : (pn == bmt_pkg::PRE_M) ? 2'h1 :
         (pn == bmt_pkg::PRE_W) ? 2'h2 : 2'h3;
    stb_o <= 1'b0;
    prev <= line_i;
    ph <= (line_i != prev) ? 1 : ((ph == R - 1) ? 0 : ph + 1);
    if (rst_i) begin
      sync <= 1'b0;
      err_o <= 0;
    end else if (ph == R - 1 && line_i == prev) begin
      sh <= s;
      if (!sync) begin
        if (s[8] != s[7] && pc != 2'h3) begin
          sync <= 1'b1;
          n <= 0;
          pre_o <= pc;
        end
      end else if (n < 56) begin
        n <= n + 1;
        if (n % 2 == 1) begin
          acc[n/2] <= s[1] ^ s[0];
          if (s[1] == s[2]) err_o <= err_o + 1;
        end
        if (n == 55) begin
          stb_o <= 1'b1;
          bits_o <= {s[1] ^ s[0], acc[26:0]};
        end
      end else if (n < 63) begin
        n <= n + 1;
      end else begin
        n <= 0;
        pre_o <= pc;
        if (s[8] == s[7] || pc == 2'h3) begin
          err_o <= err_o + 1;
          sync <= 1'b0;
        end
      end
    end
  end
endmodule
